/* File: bench/lpf_far_model.sv */
`timescale 1ns/1ns
`default_nettype none
module lpf_far_model (
   // system clock
   input wire logic clk,
   // requests from the bench
   input wire logic tck_go,
   input wire logic halt_want,
   // debug pins
   output logic test_clock_in,
   output logic halt_request_pin
);
   // test clock runs only while asked, idle low between uses;
   // halt pin moves with each falling edge, steady at each rise
   initial begin
      test_clock_in = 1'b0;
      halt_request_pin = 1'b0;
      forever begin
         #35;
         if (test_clock_in) begin
            halt_request_pin = halt_want;
         end
         test_clock_in = tck_go ? ~test_clock_in : 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: bench/lpf_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
err_count++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module lpf_top_tb;
   import lpf_pkg::*;
   logic clk = 0, rst = 1, stop_exec = 0, tck_go = 0, halt_want = 0;
   logic [1:0] sleep_kind = 0;
   logic [2:0] sr_mask = 0, wake_priority_level = 0;
   logic [13:0] intc_unmask = '1;
   logic [41:0] src_lvl = '1;
   logic wdt_on = 1, wdt_stop_wait = 0, wdt_stop_doze = 0, wdt_timeout = 0;
   logic [3:0] pit_on = 4'hF, pit_stop_doze = 0, pit_irq = 0;
   logic [3:0] dt_on = 4'hF, timer_dma_route = 0, match_irq_on = 0;
   logic [3:0] dt_capture = 0, dt_match = 0;
   logic [7:0] dt_capture_edge = 0;
   logic port_on = 1, qspi_irq = 0, module_on = 1, irq_allow = 1;
   logic [2:0] tx_enable = 3'h1, rx_enable = 3'h2, uart_irq = 0;
   logic i2c_byte_done = 0, i2c_addr_match = 0, i2c_slave_rx = 0;
   logic i2c_flag_clr = 0, edge_pin_n = 1, edge_lvl_on = 1;
   logic edge_fall_on = 0;
   wire test_clock_in, halt_request_pin;
   logic [1:0] lp_mode_r;
   logic core_clk_en_r, sram_clk_en_r, pm_clk_en_r, ccm_clk_en_r;
   logic aon_clk_en_r, debug_halt_r, wdt_run_r, qspi_run_r, i2c_run_r;
   logic edge_detect_en_r, wdt_reset_r, irq_flag_r, i2c_irq_r;
   logic irq_service_r;
   logic [3:0] pit_run_r, dt_run_r, dt_irq_r, service_src_r;
   logic [2:0] uart_run_r;
   int err_count = 0, comparisons = 0, cyc = 0, i;
   lpf_top uut (.clk(clk), .rst(rst), .stop_exec(stop_exec),
      .sleep_kind(sleep_kind), .sr_mask(sr_mask),
      .wake_priority_level(wake_priority_level), .intc_unmask(intc_unmask),
      .src_lvl(src_lvl), .wdt_on(wdt_on), .wdt_stop_wait(wdt_stop_wait),
      .wdt_stop_doze(wdt_stop_doze), .wdt_timeout(wdt_timeout),
      .pit_on(pit_on), .pit_stop_doze(pit_stop_doze), .pit_irq(pit_irq),
      .dt_on(dt_on), .dt_capture_edge(dt_capture_edge),
      .timer_dma_route(timer_dma_route), .match_irq_on(match_irq_on),
      .dt_capture(dt_capture), .dt_match(dt_match), .port_on(port_on),
      .qspi_irq(qspi_irq), .tx_enable(tx_enable), .rx_enable(rx_enable),
      .uart_irq(uart_irq), .module_on(module_on), .irq_allow(irq_allow),
      .i2c_byte_done(i2c_byte_done), .i2c_addr_match(i2c_addr_match),
      .i2c_slave_rx(i2c_slave_rx), .i2c_flag_clr(i2c_flag_clr),
      .edge_pin_n(edge_pin_n), .edge_lvl_on(edge_lvl_on),
      .edge_fall_on(edge_fall_on), .test_clock_in(test_clock_in),
      .halt_request_pin(halt_request_pin), .lp_mode_r(lp_mode_r),
      .core_clk_en_r(core_clk_en_r), .sram_clk_en_r(sram_clk_en_r),
      .pm_clk_en_r(pm_clk_en_r), .ccm_clk_en_r(ccm_clk_en_r),
      .aon_clk_en_r(aon_clk_en_r), .debug_halt_r(debug_halt_r),
      .wdt_run_r(wdt_run_r), .pit_run_r(pit_run_r), .dt_run_r(dt_run_r),
      .qspi_run_r(qspi_run_r), .uart_run_r(uart_run_r),
      .i2c_run_r(i2c_run_r), .edge_detect_en_r(edge_detect_en_r),
      .wdt_reset_r(wdt_reset_r), .dt_irq_r(dt_irq_r),
      .irq_flag_r(irq_flag_r), .i2c_irq_r(i2c_irq_r),
      .irq_service_r(irq_service_r), .service_src_r(service_src_r));
   lpf_far_model far (.clk(clk), .tck_go(tck_go), .halt_want(halt_want),
      .test_clock_in(test_clock_in), .halt_request_pin(halt_request_pin));
   // 25 MHz system clock
   initial begin
      forever #20 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         close_out();
      end
   end
   // one edge, then drive just after it
   task step();
      @(posedge clk);
      #1;
   endtask
   // stop instruction with the target mode
   task enter(input logic [1:0] k);
      stop_exec = 1;
      sleep_kind = k;
      step();
      stop_exec = 0;
   endtask
   // bounded wait for an interrupt wake
   task wake_wait(input logic [3:0] src);
      for (i = 0; i < 30 && irq_service_r !== 1'b1; i++) step();
      `CHK("service", 1'b1, irq_service_r)
      `CHK("source", src, service_src_r)
      `CHK("mode", 2'h0, lp_mode_r)
   endtask
   task t_reset();
      `CHK("mode", 2'h0, lp_mode_r)
      `CHK("edge det", 1'b1, edge_detect_en_r)
      step();
      `CHK("qspi", 1'b1, qspi_run_r)
      `CHK("uart", 3'h3, uart_run_r)
      port_on = 0;
      step();
      step();
      `CHK("qspi off", 1'b0, qspi_run_r)
      port_on = 1;
      $display("test reset done");
   endtask
   task t_stop();
      enter(2'h3);
      `CHK("mode", 2'h3, lp_mode_r)
      `CHK("core sram", 2'h0, {core_clk_en_r, sram_clk_en_r})
      `CHK("pm ccm aon", 3'h1, {pm_clk_en_r, ccm_clk_en_r, aon_clk_en_r})
      `CHK("edge det", 1'b0, edge_detect_en_r)
      `CHK("runs", 17'h0, {wdt_run_r, pit_run_r, dt_run_r, qspi_run_r,
         uart_run_r, i2c_run_r})
      i2c_byte_done = 1;
      step();
      i2c_byte_done = 0;
      `CHK("i2c frozen", 1'b0, irq_flag_r)
      edge_pin_n = 0;
      wake_wait(4'hD);
      edge_pin_n = 1;
      repeat (2) step();
      `CHK("enables", 3'h7, {core_clk_en_r, pm_clk_en_r,
         edge_detect_en_r})
      `CHK("resume", 12'hFF7, {pit_run_r, dt_run_r, uart_run_r,
         qspi_run_r})
      $display("test stop done");
   endtask
   task t_wait();
      enter(2'h1);
      `CHK("mode", 2'h1, lp_mode_r)
      `CHK("core pm", 2'h1, {core_clk_en_r, pm_clk_en_r})
      `CHK("wdt run", 1'b1, wdt_run_r)
      wdt_timeout = 1;
      step();
      wdt_timeout = 0;
      `CHK("wdt reset", 1'b1, wdt_reset_r)
      `CHK("mode", 2'h0, lp_mode_r)
      `CHK("reset wake", 1'b0, irq_service_r)
      wdt_stop_wait = 1;
      enter(2'h1);
      `CHK("wdt held", 1'b0, wdt_run_r)
      wdt_timeout = 1;
      tck_go = 1;
      repeat (20) step();
      wdt_timeout = 0;
      tck_go = 0;
      `CHK("no reset", 1'b0, wdt_reset_r)
      `CHK("no wake", 2'h1, lp_mode_r)
      pit_irq = 4'h8;
      wake_wait(4'h3);
      pit_irq = 0;
      $display("test wait done");
   endtask
   task t_doze();
      wdt_stop_doze = 1;
      pit_stop_doze = 4'h1;
      src_lvl[5:3] = 3'h0;
      enter(2'h2);
      `CHK("pit run", 4'hE, pit_run_r)
      `CHK("wdt held", 1'b0, wdt_run_r)
      pit_irq = 4'h3;
      repeat (8) step();
      `CHK("refused", 2'h2, lp_mode_r)
      pit_irq = 0;
      halt_want = 1;
      tck_go = 1;
      for (i = 0; i < 60 && debug_halt_r !== 1'b1; i++) step();
      `CHK("halt", 4'h9, {debug_halt_r, lp_mode_r, core_clk_en_r})
      halt_want = 0;
      for (i = 0; i < 60 && debug_halt_r !== 1'b0; i++) step();
      tck_go = 0;
      `CHK("back", 3'h2, {debug_halt_r, lp_mode_r})
      step();
      `CHK("pit run", 4'hE, pit_run_r)
      src_lvl[5:3] = 3'h7;
      pit_irq = 4'h2;
      wake_wait(4'h1);
      pit_irq = 0;
      $display("test doze done");
   endtask
   task t_events();
      dt_capture_edge = 8'h05;
      timer_dma_route = 4'h2;
      match_irq_on = 4'h4;
      dt_capture = 4'h3;
      dt_match = 4'hC;
      step();
      dt_capture = 0;
      dt_match = 0;
      `CHK("dt irq", 4'h5, dt_irq_r)
      enter(2'h1);
      dt_capture = 4'h1;
      step();
      dt_capture = 0;
      wake_wait(4'h4);
      i2c_byte_done = 1;
      step();
      i2c_byte_done = 0;
      `CHK("i2c flag", 1'b1, irq_flag_r)
      step();
      `CHK("i2c irq", 1'b1, i2c_irq_r)
      i2c_flag_clr = 1;
      i2c_addr_match = 1;
      step();
      `CHK("addr only", 1'b0, irq_flag_r)
      i2c_slave_rx = 1;
      irq_allow = 0;
      step();
      i2c_flag_clr = 0;
      step();
      `CHK("addr rx", 2'h2, {irq_flag_r, i2c_irq_r})
      $display("test events done");
   endtask
   task close_out();
      $display("checks %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (16) step();
      rst = 0;
      step();
      t_reset();
      t_stop();
      t_wait();
      t_doze();
      t_events();
      close_out();
   end
endmodule
`default_nettype wire

/* File: core/lpf_pkg.sv */
// Contract
// - watchdog holds count in stop, programmed wait/doze
// - running watchdog reset ends low-power mode
// - periodic timers hold in stop, programmed doze
// - running periodic timer interrupt wakes device
// - capture without dma route raises wake interrupt
// - reference match without dma route raises interrupt
// - capture timers stop only in stop mode
// - serial port freezes, clocks gated in stop
// - serial port off when port_on clear
// - uart off when tx/rx enable clear
// - uarts freeze in stop, resume exact state
// - i2c runs when on, not in stop
// - i2c flag on byte done or address match with slave receive
// - i2c freezes in stop, resumes after
// - test port never wakes, own test clock
// - halt pin forces debug halt, exits sleep
// - halt end returns to prior low-power mode
// - stop instruction with sleep_kind enters mode
// - interrupt wake starts servicing that exception
// - fixed per-mode enables for core, sram, others
// - wake needs priority, unmask, source enable
// - stop keeps only level detection on edge port
package lpf_pkg;
   localparam int LPF_NPIT = 4;
   localparam int LPF_NDT = 4;
   localparam int LPF_NUART = 3;
   localparam int LPF_LVL_W = 3;
   localparam int LPF_CE_W = 2;
   localparam logic [LPF_CE_W-1:0] LPF_CE_OFF = 2'h0;
   // decoded low-power mode as carried by sleep_kind
   typedef enum logic [1:0] {
      LPF_K_RUN = 2'h0,
      LPF_K_WAIT = 2'h1,
      LPF_K_DOZE = 2'h2,
      LPF_K_STOP = 2'h3
   } lpf_kind_e;
   // sequencer states, gray along run-wait-doze-stop-halt
   typedef enum logic [2:0] {
      LPF_S_RUN = 3'h0,
      LPF_S_WAIT = 3'h1,
      LPF_S_DOZE = 3'h3,
      LPF_S_STOP = 3'h2,
      LPF_S_HALT = 3'h6
   } lpf_state_e;
endpackage

/* File: core/lpf_top.sv */
`timescale 1ns/1ns
`default_nettype none
module lpf_top
   import lpf_pkg::*;
#(
   parameter int NPIT = LPF_NPIT,
   parameter int NDT = LPF_NDT,
   parameter int NUART = LPF_NUART
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // cpu stop instruction
   input wire logic stop_exec,
   input wire logic [1:0] sleep_kind,
   // wake qualification
   input wire logic [LPF_LVL_W-1:0] sr_mask,
   input wire logic [LPF_LVL_W-1:0] wake_priority_level,
   input wire logic [NPIT+NDT+NUART+2:0] intc_unmask,
   input wire logic [(NPIT+NDT+NUART+3)*LPF_LVL_W-1:0] src_lvl,
   // watchdog
   input wire logic wdt_on,
   input wire logic wdt_stop_wait,
   input wire logic wdt_stop_doze,
   input wire logic wdt_timeout,
   // periodic timers
   input wire logic [NPIT-1:0] pit_on,
   input wire logic [NPIT-1:0] pit_stop_doze,
   input wire logic [NPIT-1:0] pit_irq,
   // capture compare timers
   input wire logic [NDT-1:0] dt_on,
   input wire logic [NDT*LPF_CE_W-1:0] dt_capture_edge,
   input wire logic [NDT-1:0] timer_dma_route,
   input wire logic [NDT-1:0] match_irq_on,
   input wire logic [NDT-1:0] dt_capture,
   input wire logic [NDT-1:0] dt_match,
   // queued serial port
   input wire logic port_on,
   input wire logic qspi_irq,
   // uarts
   input wire logic [NUART-1:0] tx_enable,
   input wire logic [NUART-1:0] rx_enable,
   input wire logic [NUART-1:0] uart_irq,
   // i2c
   input wire logic module_on,
   input wire logic irq_allow,
   input wire logic i2c_byte_done,
   input wire logic i2c_addr_match,
   input wire logic i2c_slave_rx,
   input wire logic i2c_flag_clr,
   // edge port
   input wire logic edge_pin_n,
   input wire logic edge_lvl_on,
   input wire logic edge_fall_on,
   // debug pins
   input wire logic test_clock_in,
   input wire logic halt_request_pin,
   // mode and clock enables
   output logic [1:0] lp_mode_r,
   output logic core_clk_en_r,
   output logic sram_clk_en_r,
   output logic pm_clk_en_r,
   output logic ccm_clk_en_r,
   output logic aon_clk_en_r,
   output logic debug_halt_r,
   // peripheral run enables
   output logic wdt_run_r,
   output logic [NPIT-1:0] pit_run_r,
   output logic [NDT-1:0] dt_run_r,
   output logic qspi_run_r,
   output logic [NUART-1:0] uart_run_r,
   output logic i2c_run_r,
   output logic edge_detect_en_r,
   // events
   output logic wdt_reset_r,
   output logic [NDT-1:0] dt_irq_r,
   output logic irq_flag_r,
   output logic i2c_irq_r,
   output logic irq_service_r,
   output logic [$clog2(NPIT+NDT+NUART+3)-1:0] service_src_r
);
   localparam int NSRC = NPIT + NDT + NUART + 3;
   localparam int SW = $clog2(NSRC);
   localparam int S_DT = NPIT;
   localparam int S_QSPI = NPIT + NDT;
   localparam int S_UART = S_QSPI + 1;
   localparam int S_I2C = S_UART + NUART;
   localparam int S_EDGE = S_I2C + 1;
   lpf_state_e state_r, state_nxt, prev_r;
   lpf_kind_e eff_kind;
   logic [1:0] tck_sync_r, halt_sync_r, edge_sync_r;
   logic tck_d_r, halt_s_r, halt_d_r, edge_d_r;
   logic tck_rise, halt_rise, edge_fall, edge_req;
   logic [NSRC-1:0] src_req, qual;
   logic irq_wake, wdt_wake, wake_any, low_pw;
   logic [SW-1:0] pick;
   function automatic lpf_state_e kind_state(input logic [1:0] k);
      case (k)
         LPF_K_WAIT: kind_state = LPF_S_WAIT;
         LPF_K_DOZE: kind_state = LPF_S_DOZE;
         LPF_K_STOP: kind_state = LPF_S_STOP;
         default: kind_state = LPF_S_RUN;
      endcase
   endfunction
   // two-flop synchronisers for pins
   always_ff @(posedge clk) begin
      if (rst) begin
         tck_sync_r <= '0;
         halt_sync_r <= '0;
         edge_sync_r <= '1;
      end else begin
         tck_sync_r <= {tck_sync_r[0], test_clock_in};
         halt_sync_r <= {halt_sync_r[0], halt_request_pin};
         edge_sync_r <= {edge_sync_r[0], edge_pin_n};
      end
   end
   // halt pin sampled on rising test clock edges only
   always_ff @(posedge clk) begin
      if (rst) begin
         tck_d_r <= 1'b0;
         halt_s_r <= 1'b0;
         halt_d_r <= 1'b0;
         edge_d_r <= 1'b1;
      end else begin
         tck_d_r <= tck_sync_r[1];
         if (tck_rise) begin
            halt_s_r <= halt_sync_r[1];
         end
         halt_d_r <= halt_s_r;
         edge_d_r <= edge_sync_r[1];
      end
   end
   assign tck_rise = tck_sync_r[1] & ~tck_d_r;
   assign halt_rise = halt_s_r & ~halt_d_r;
   assign edge_fall = edge_d_r & ~edge_sync_r[1];
   // level detect always on, edge detect needs system clock
   assign edge_req = (edge_lvl_on & ~edge_sync_r[1]) |
      (edge_fall_on & edge_detect_en_r & edge_fall);
   // wake sources gated by their run enables
   genvar g;
   generate
      for (g = 0; g < NPIT; g++) begin : g_pit
         assign src_req[g] = pit_irq[g] & pit_run_r[g];
         // run enable, count holds while low
         always_ff @(posedge clk) begin
            if (rst) begin
               pit_run_r[g] <= 1'b0;
            end else begin
               pit_run_r[g] <= pit_on[g] & (eff_kind != LPF_K_STOP) &
                  ~((eff_kind == LPF_K_DOZE) & pit_stop_doze[g]);
            end
         end
      end
      for (g = 0; g < NDT; g++) begin : g_dt
         logic cap_mode, cmp_mode;
         assign cap_mode = (dt_capture_edge[g*LPF_CE_W +: LPF_CE_W]
            != LPF_CE_OFF) & ~timer_dma_route[g];
         assign cmp_mode = match_irq_on[g] & ~timer_dma_route[g];
         assign src_req[S_DT+g] = dt_run_r[g] &
            ((cap_mode & dt_capture[g]) | (cmp_mode & dt_match[g]));
         // timer interrupt line
         always_ff @(posedge clk) begin
            if (rst) begin
               dt_irq_r[g] <= 1'b0;
            end else begin
               dt_irq_r[g] <= src_req[S_DT+g];
            end
         end
         // run enable, unaffected by wait and doze
         always_ff @(posedge clk) begin
            if (rst) begin
               dt_run_r[g] <= 1'b0;
            end else begin
               dt_run_r[g] <= dt_on[g] & (eff_kind != LPF_K_STOP);
            end
         end
      end
      for (g = 0; g < NUART; g++) begin : g_uart
         assign src_req[S_UART+g] = uart_irq[g] & uart_run_r[g];
         // run enable, frozen in stop
         always_ff @(posedge clk) begin
            if (rst) begin
               uart_run_r[g] <= 1'b0;
            end else begin
               uart_run_r[g] <= (tx_enable[g] | rx_enable[g]) &
                  (eff_kind != LPF_K_STOP);
            end
         end
      end
      for (g = 0; g < NSRC; g++) begin : g_qual
         logic [LPF_LVL_W-1:0] lvl;
         assign lvl = src_lvl[g*LPF_LVL_W +: LPF_LVL_W];
         assign qual[g] = src_req[g] & intc_unmask[g] &
            (lvl >= sr_mask) & (lvl > wake_priority_level);
      end
   endgenerate
   assign src_req[S_QSPI] = qspi_irq & qspi_run_r;
   assign src_req[S_I2C] = i2c_irq_r;
   assign src_req[S_EDGE] = edge_req;
   // lowest index qualified source is serviced first
   always_comb begin
      pick = '0;
      for (int k = NSRC - 1; k >= 0; k--) begin
         if (qual[k]) begin
            pick = SW'(k);
         end
      end
   end
   assign low_pw = (state_r != LPF_S_RUN) & (state_r != LPF_S_HALT);
   assign irq_wake = low_pw & (|qual);
   assign wdt_wake = low_pw & wdt_timeout & wdt_run_r;
   // test access logic has no source here
   assign wake_any = irq_wake | wdt_wake;
   // mode sequencer next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         LPF_S_RUN: begin
            if (halt_rise) begin
               state_nxt = LPF_S_HALT;
            end else if (stop_exec) begin
               state_nxt = kind_state(sleep_kind);
            end
         end
         LPF_S_WAIT, LPF_S_DOZE, LPF_S_STOP: begin
            if (halt_rise) begin
               state_nxt = LPF_S_HALT;
            end else if (wake_any) begin
               state_nxt = LPF_S_RUN;
            end
         end
         LPF_S_HALT: begin
            if (!halt_s_r) begin
               state_nxt = prev_r;
            end
         end
         default: state_nxt = LPF_S_RUN;
      endcase
   end
   // prior state kept in prev_r across a debug halt, mode shows run
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= LPF_S_RUN;
         prev_r <= LPF_S_RUN;
      end else begin
         state_r <= state_nxt;
         if (state_r != LPF_S_HALT && state_nxt == LPF_S_HALT) begin
            prev_r <= state_r;
         end
      end
   end
   // peripherals see run behaviour while halted
   always_comb begin
      case (state_nxt)
         LPF_S_WAIT: eff_kind = LPF_K_WAIT;
         LPF_S_DOZE: eff_kind = LPF_K_DOZE;
         LPF_S_STOP: eff_kind = LPF_K_STOP;
         default: eff_kind = LPF_K_RUN;
      endcase
   end
   // system level enables per mode
   always_ff @(posedge clk) begin
      if (rst) begin
         lp_mode_r <= LPF_K_RUN;
         core_clk_en_r <= 1'b1;
         sram_clk_en_r <= 1'b1;
         pm_clk_en_r <= 1'b1;
         ccm_clk_en_r <= 1'b1;
         aon_clk_en_r <= 1'b1;
         debug_halt_r <= 1'b0;
      end else begin
         lp_mode_r <= eff_kind;
         core_clk_en_r <= (eff_kind == LPF_K_RUN);
         sram_clk_en_r <= (eff_kind == LPF_K_RUN);
         pm_clk_en_r <= (eff_kind != LPF_K_STOP);
         ccm_clk_en_r <= (eff_kind != LPF_K_STOP);
         aon_clk_en_r <= 1'b1;
         debug_halt_r <= (state_nxt == LPF_S_HALT);
      end
   end
   // watchdog, edge port, serial port and i2c enables
   always_ff @(posedge clk) begin
      if (rst) begin
         wdt_run_r <= 1'b0;
         edge_detect_en_r <= 1'b1;
         wdt_reset_r <= 1'b0;
         qspi_run_r <= 1'b0;
         i2c_run_r <= 1'b0;
      end else begin
         wdt_run_r <= wdt_on & (eff_kind != LPF_K_STOP) &
            ~((eff_kind == LPF_K_WAIT) & wdt_stop_wait) &
            ~((eff_kind == LPF_K_DOZE) & wdt_stop_doze);
         edge_detect_en_r <= (eff_kind != LPF_K_STOP);
         wdt_reset_r <= wdt_timeout & wdt_run_r;
         qspi_run_r <= port_on & (eff_kind != LPF_K_STOP);
         i2c_run_r <= module_on & (eff_kind != LPF_K_STOP);
      end
   end
   // i2c flag, set wins over clear
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_flag_r <= 1'b0;
         i2c_irq_r <= 1'b0;
      end else begin
         if (i2c_run_r & (i2c_byte_done |
            (i2c_addr_match & i2c_slave_rx))) begin
            irq_flag_r <= 1'b1;
         end else if (i2c_flag_clr) begin
            irq_flag_r <= 1'b0;
         end
         i2c_irq_r <= irq_flag_r & irq_allow & i2c_run_r;
      end
   end
   // exception service request after interrupt wake
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_service_r <= 1'b0;
         service_src_r <= '0;
      end else begin
         irq_service_r <= irq_wake & ~halt_rise;
         if (irq_wake & ~halt_rise) begin
            service_src_r <= pick;
         end
      end
   end
   AST_ENTER_STOP: assert property (@(posedge clk) disable iff (rst)
      (state_r == LPF_S_RUN) && stop_exec && !halt_rise &&
      (sleep_kind == LPF_K_STOP) |=> (state_r == LPF_S_STOP) &&
      (lp_mode_r == LPF_K_STOP))
      else $error("stop not entered");
   AST_WDT_HOLD: assert property (@(posedge clk) disable iff (rst)
      (state_r == LPF_S_STOP) ||
      ((state_r == LPF_S_WAIT) && $past(wdt_stop_wait)) |-> !wdt_run_r)
      else $error("watchdog runs while held");
   AST_WDT_WAKE: assert property (@(posedge clk) disable iff (rst)
      (state_r == LPF_S_WAIT) && wdt_run_r && wdt_timeout && !halt_rise
      |=> (state_r == LPF_S_RUN) && wdt_reset_r)
      else $error("watchdog reset did not wake");
   AST_PIT_STOP: assert property (@(posedge clk) disable iff (rst)
      (state_r == LPF_S_STOP) |-> (pit_run_r == '0) && (dt_run_r == '0))
      else $error("timer runs in stop");
   AST_SER_STOP: assert property (@(posedge clk) disable iff (rst)
      (state_r == LPF_S_STOP) |-> !qspi_run_r && (uart_run_r == '0))
      else $error("serial clocks on in stop");
   AST_I2C_FLAG: assert property (@(posedge clk) disable iff (rst)
      i2c_run_r && i2c_byte_done |=> irq_flag_r ##1
      (i2c_irq_r == $past(irq_allow && i2c_run_r)))
      else $error("i2c flag or irq wrong");
   AST_IRQ_WAKE: assert property (@(posedge clk) disable iff (rst)
      irq_wake && !halt_rise |=> irq_service_r &&
      (state_r == LPF_S_RUN) && (service_src_r == $past(pick)))
      else $error("interrupt wake not serviced");
   AST_HALT_BACK: assert property (@(posedge clk) disable iff (rst)
      (state_r == LPF_S_HALT) && !halt_s_r |=>
      (state_r == $past(prev_r)) && !debug_halt_r)
      else $error("halt exit lost prior mode");
   AST_CORE_EN: assert property (@(posedge clk) disable iff (rst)
      core_clk_en_r == (lp_mode_r == LPF_K_RUN) &&
      pm_clk_en_r == (lp_mode_r != LPF_K_STOP))
      else $error("core or pm enable mismatch");
   AST_EDGE_STOP: assert property (@(posedge clk) disable iff (rst)
      (state_r == LPF_S_STOP) |-> !edge_detect_en_r)
      else $error("edge detect on in stop");
endmodule
`default_nettype wire

/* File: core/lpf_top_dummy_guard.sv */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire
